// file: lfrb_params.svh
// Constants of the flash LED driver register bank: addresses, limits, defaults, field positions, timing.
// Assumes inclusion by the idle watch and bank files, not the package; holds definitions only.
`ifndef LFRB_PARAMS_SVH
`define LFRB_PARAMS_SVH

// ****************************************************************
// Register addresses and largest accepted data values
// ****************************************************************
`define LFRB_ADDR_FLASH 6'h01
`define LFRB_ADDR_TORCH 6'h02
`define LFRB_ADDR_DUR 6'h03
`define LFRB_ADDR_LBAT 6'h04
`define LFRB_ADDR_STH 6'h05
`define LFRB_MAX_FLASH 6'h1f
`define LFRB_MAX_TORCH 6'h1f
`define LFRB_MAX_DUR 6'h07
`define LFRB_MAX_LBAT 6'h09
`define LFRB_MAX_STH 6'h05

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define LFRB_RST_FLASH 5'h04
`define LFRB_RST_TORCH 5'h04
`define LFRB_RST_DUR 3'h7
`define LFRB_RST_LBAT 4'h1
`define LFRB_RST_STH 3'h4
`define LFRB_EN_BIT 4
`define LFRB_CODE_MSB 3
`define LFRB_CODE_STEEP_LAST 4'hd
`define LFRB_CODE_14 4'he
`define LFRB_OFF_CODE 4'h0

// ****************************************************************
// Currents in units of 0.1 mA
// ****************************************************************
`define LFRB_FL_BASE 14'h2ee0
`define LFRB_FL_STEP 14'h01f4
`define LFRB_FL_C14 14'h0fa0
`define LFRB_FL_C15 14'h09c4
`define LFRB_TO_BASE 14'h0bb8
`define LFRB_TO_STEP 14'h007d
`define LFRB_TO_C14 14'h03e8
`define LFRB_TO_C15 14'h0271
`define LFRB_TH_STEP 14'h01f4
`define LFRB_RST_FL_CUR 14'h2710
`define LFRB_RST_TO_CUR 14'h09c4

// ****************************************************************
// Timing
// ****************************************************************
`define LFRB_CLK_MHZ 125
`define LFRB_SHUTDOWN_US 405
`define LFRB_TIMER_STEP_US 156250

`endif

// file: lfrb_pkg.sv
// Types shared by the flash LED driver register bank.
// Assumes nothing of its surroundings.
package lfrb_pkg;

  // Safety timer states, one-hot.
  typedef enum logic [2:0] {
    LFRB_T_IDLE = 3'b001,
    LFRB_T_RUN = 3'b010,
    LFRB_T_EXPIRED = 3'b100
  } lfrb_timer_state_t;

  // Pulse count as delivered by the frame receiver.
  typedef logic [5:0] lfrb_count_t;

  // Current in units of 0.1 mA.
  typedef logic [13:0] lfrb_tenth_ma_t;

endpackage

// file: lfrb_idle_watch.sv
// Watches the single-wire control line and reports shutdown after a long low period.
// Assumes a raw asynchronous line input and an already synchronised active-low reset.
`timescale 1ns/1ps
`include "lfrb_params.svh"

module lfrb_idle_watch #(
  parameter int unsigned SHUTDOWN_CYCLES = `LFRB_SHUTDOWN_US * `LFRB_CLK_MHZ
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Raw control line from the pin.
  input wire logic single_wire_control_line_i,
  // Shutdown level.
  output logic shutdown_o
);

  logic meta_q;
  logic meta_d;
  logic line_q;
  logic line_d;
  logic [31:0] low_cnt_q;
  logic [31:0] low_cnt_d;
  logic shutdown_q;
  logic shutdown_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Count uninterrupted low cycles; any high level restarts the count and ends shutdown.
  always_comb begin
    meta_d = single_wire_control_line_i;
    line_d = meta_q;
    low_cnt_d = low_cnt_q;
    shutdown_d = shutdown_q;
    if (line_q) begin
      low_cnt_d = 32'h0000_0000;
      shutdown_d = 1'b0;
    end else if (low_cnt_q >= SHUTDOWN_CYCLES - 32'h0000_0001) begin
      shutdown_d = 1'b1;
    end else begin
      low_cnt_d = low_cnt_q + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // The synchroniser starts low, but the first high sample restarts the count, so reset gives no false shutdown.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      line_q <= 1'b0;
      low_cnt_q <= 32'h0000_0000;
      shutdown_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      line_q <= line_d;
      low_cnt_q <= low_cnt_d;
      shutdown_q <= shutdown_d;
    end
  end

  assign shutdown_o = shutdown_q;

endmodule

// file: lfrb_bank.sv
// Write-only register bank of a flash LED driver, fed by a decoded single-wire frame.
// Assumes a frame receiver on clk_i that delivers address and data pulse counts with a one-cycle valid,
// and analog sections that act on the registered enables and codes.
`timescale 1ns/1ps
`include "lfrb_params.svh"

// Functional notes
// - Five registers sit at addresses one to five; address zero is not a register.
// - Data above the register maximum (31,31,7,9,5) discards the whole frame.
// - Flash word is five bits, reset four; bit four enables, bits three-zero set current.
// - Flash words 0-15 set current only, leaving flash enabled by the external input.
// - Flash code: 1.200 A minus 0.050 A per step to 13, then 0.400, 0.250.
// - Torch word is five bits, reset four; bit four enables, bits three-zero set current.
// - Torch words 0-15 set current with enable cleared; torch runs only while enabled.
// - Torch code: 300.0 mA minus 12.5 mA per step to 13, then 100.0, 62.5.
// - Timer duration is three bits, reset seven; timeout is 156.25 ms times code plus one.
// - Safety timer limits flash and torch only while current exceeds the threshold.
// - Low-battery threshold is four bits, reset one; zero disables, 1-9 give 3.0-3.8 V.
// - Enabled and supply below threshold raises the low-battery flag and stops the driver.
// - Timer current threshold zero disables the timer; 1-5 give 100-300 mA.
// - Control line low beyond 405 us enters shutdown and restores every default.
// - A frame for an invalid address is discarded, leaving every register unchanged.
module lfrb_bank import lfrb_pkg::*; #(
  parameter int unsigned SHUTDOWN_CYCLES = `LFRB_SHUTDOWN_US * `LFRB_CLK_MHZ,
  parameter int unsigned TIMER_STEP_CYCLES = `LFRB_TIMER_STEP_US * `LFRB_CLK_MHZ
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Pins from outside the clock domain.
  input wire logic single_wire_control_line_i,
  input wire logic flash_trigger_i,
  input wire logic supply_below_threshold_i,
  // Decoded frame from the receiver.
  input wire logic frame_valid_i,
  input wire lfrb_count_t frame_addr_i,
  input wire lfrb_count_t frame_data_i,
  // Frame result.
  output logic frame_accepted_o,
  output logic frame_rejected_o,
  // Stored register contents.
  output logic flash_enable_bit_o,
  output logic [3:0] flash_current_code_o,
  output logic torch_enable_bit_o,
  output logic [3:0] torch_current_code_o,
  output logic [2:0] safety_timer_duration_o,
  output logic [3:0] low_battery_threshold_o,
  output logic [2:0] safety_current_threshold_o,
  // Decoded currents in 0.1 mA.
  output lfrb_tenth_ma_t flash_current_o,
  output lfrb_tenth_ma_t torch_current_o,
  // Driver control and status.
  output logic flash_drive_o,
  output logic torch_drive_o,
  output logic low_battery_flag_o,
  output logic safety_timeout_o,
  output logic shutdown_o
);

  // ****************************************************************
  // Current maps
  // ****************************************************************
  // Flash code to current; the two highest codes leave the linear slope.
  function automatic lfrb_tenth_ma_t flash_ma(input logic [3:0] code);
    if (code <= `LFRB_CODE_STEEP_LAST) begin
      flash_ma = 14'(`LFRB_FL_BASE - `LFRB_FL_STEP * 14'(code));
    end else if (code == `LFRB_CODE_14) begin
      flash_ma = `LFRB_FL_C14;
    end else begin
      flash_ma = `LFRB_FL_C15;
    end
  endfunction

  // Torch code to current.
  function automatic lfrb_tenth_ma_t torch_ma(input logic [3:0] code);
    if (code <= `LFRB_CODE_STEEP_LAST) begin
      torch_ma = 14'(`LFRB_TO_BASE - `LFRB_TO_STEP * 14'(code));
    end else if (code == `LFRB_CODE_14) begin
      torch_ma = `LFRB_TO_C14;
    end else begin
      torch_ma = `LFRB_TO_C15;
    end
  endfunction

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] trig_sync_q;
  logic [1:0] below_sync_q;
  logic shutdown;

  // Reset is asserted at once and released two edges later.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Only the second stage of each synchroniser is read.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync_q <= 2'b00;
      below_sync_q <= 2'b00;
    end else begin
      trig_sync_q <= {trig_sync_q[0], flash_trigger_i};
      below_sync_q <= {below_sync_q[0], supply_below_threshold_i};
    end
  end

  lfrb_idle_watch #(
    .SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)
  ) u_idle_watch (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .single_wire_control_line_i(single_wire_control_line_i),
    .shutdown_o(shutdown)
  );

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [4:0] flash_q;
  logic [4:0] flash_d;
  logic [4:0] torch_q;
  logic [4:0] torch_d;
  logic [2:0] dur_q;
  logic [2:0] dur_d;
  logic [3:0] lbat_q;
  logic [3:0] lbat_d;
  logic [2:0] sth_q;
  logic [2:0] sth_d;
  logic acc_q;
  logic acc_d;
  logic rej_q;
  logic rej_d;
  logic data_ok;
  logic addr_ok;

  // Validate the frame, then write one register; a bad frame touches nothing.
  always_comb begin
    flash_d = flash_q;
    torch_d = torch_q;
    dur_d = dur_q;
    lbat_d = lbat_q;
    sth_d = sth_q;
    addr_ok = 1'b1;
    data_ok = 1'b0;
    case (frame_addr_i)
      `LFRB_ADDR_FLASH: data_ok = frame_data_i <= `LFRB_MAX_FLASH;
      `LFRB_ADDR_TORCH: data_ok = frame_data_i <= `LFRB_MAX_TORCH;
      `LFRB_ADDR_DUR: data_ok = frame_data_i <= `LFRB_MAX_DUR;
      `LFRB_ADDR_LBAT: data_ok = frame_data_i <= `LFRB_MAX_LBAT;
      `LFRB_ADDR_STH: data_ok = frame_data_i <= `LFRB_MAX_STH;
      default: addr_ok = 1'b0;
    endcase
    acc_d = frame_valid_i && !shutdown && addr_ok && data_ok;
    rej_d = frame_valid_i && !acc_d;
    if (shutdown) begin
      // Shutdown wins over any frame and restores every default.
      flash_d = `LFRB_RST_FLASH;
      torch_d = `LFRB_RST_TORCH;
      dur_d = `LFRB_RST_DUR;
      lbat_d = `LFRB_RST_LBAT;
      sth_d = `LFRB_RST_STH;
    end else if (acc_d) begin
      case (frame_addr_i)
        `LFRB_ADDR_FLASH: flash_d = frame_data_i[4:0];
        `LFRB_ADDR_TORCH: torch_d = frame_data_i[4:0];
        `LFRB_ADDR_DUR: dur_d = frame_data_i[2:0];
        `LFRB_ADDR_LBAT: lbat_d = frame_data_i[3:0];
        `LFRB_ADDR_STH: sth_d = frame_data_i[2:0];
        default: flash_d = flash_q;
      endcase
    end
  end

  // Register stage; contents change only on an accepted frame or shutdown.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flash_q <= `LFRB_RST_FLASH;
      torch_q <= `LFRB_RST_TORCH;
      dur_q <= `LFRB_RST_DUR;
      lbat_q <= `LFRB_RST_LBAT;
      sth_q <= `LFRB_RST_STH;
      acc_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      flash_q <= flash_d;
      torch_q <= torch_d;
      dur_q <= dur_d;
      lbat_q <= lbat_d;
      sth_q <= sth_d;
      acc_q <= acc_d;
      rej_q <= rej_d;
    end
  end

  // ****************************************************************
  // Safety timer and driver control
  // ****************************************************************
  lfrb_timer_state_t tstate_q;
  lfrb_timer_state_t tstate_d;
  logic [31:0] tcnt_q;
  logic [31:0] tcnt_d;
  logic [31:0] tlimit;
  logic flash_act;
  logic torch_act;
  logic over_th;
  logic lowbat_d;
  logic lowbat_q;
  logic fdrv_d;
  logic fdrv_q;
  logic tdrv_d;
  logic tdrv_q;
  lfrb_tenth_ma_t flash_current_code_q;
  lfrb_tenth_ma_t torch_current_code_q;
  lfrb_tenth_ma_t act_cur;
  lfrb_tenth_ma_t th_cur;

  // The timer runs only while the programmed current of the active mode exceeds the threshold.
  // Expiry holds the driver off until both flash and torch requests are dropped or shutdown comes, so a stuck command cannot overheat.
  always_comb begin
    flash_act = flash_q[`LFRB_EN_BIT] || trig_sync_q[1];
    torch_act = torch_q[`LFRB_EN_BIT];
    act_cur = flash_act ? flash_current_code_q : torch_current_code_q;
    th_cur = 14'(`LFRB_TH_STEP * (14'(sth_q) + 14'h0001));
    over_th = (sth_q != 3'h0) && (flash_act || torch_act) && (act_cur > th_cur);
    tlimit = TIMER_STEP_CYCLES * (32'(dur_q) + 32'h0000_0001);
    tstate_d = tstate_q;
    tcnt_d = tcnt_q;
    case (tstate_q)
      LFRB_T_IDLE: begin
        tcnt_d = 32'h0000_0000;
        if (over_th) begin
          tstate_d = LFRB_T_RUN;
        end
      end
      LFRB_T_RUN: begin
        tcnt_d = tcnt_q + 32'h0000_0001;
        if (!over_th) begin
          tstate_d = LFRB_T_IDLE;
        end else if (tcnt_q >= tlimit - 32'h0000_0001) begin
          tstate_d = LFRB_T_EXPIRED;
        end
      end
      LFRB_T_EXPIRED: begin
        if (!flash_act && !torch_act) begin
          tstate_d = LFRB_T_IDLE;
        end
      end
      default: tstate_d = LFRB_T_IDLE;
    endcase
    if (shutdown) begin
      tstate_d = LFRB_T_IDLE;
    end
    lowbat_d = (lbat_q != `LFRB_OFF_CODE) && below_sync_q[1];
    fdrv_d = flash_act && !lowbat_d && (tstate_d != LFRB_T_EXPIRED) && !shutdown;
    tdrv_d = torch_act && !flash_act && !lowbat_d && (tstate_d != LFRB_T_EXPIRED) && !shutdown;
  end

  // Timer, flag, drive and decoded current registers.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tstate_q <= LFRB_T_IDLE;
      tcnt_q <= 32'h0000_0000;
      lowbat_q <= 1'b0;
      fdrv_q <= 1'b0;
      tdrv_q <= 1'b0;
      flash_current_code_q <= `LFRB_RST_FL_CUR;
      torch_current_code_q <= `LFRB_RST_TO_CUR;
    end else begin
      tstate_q <= tstate_d;
      tcnt_q <= tcnt_d;
      lowbat_q <= lowbat_d;
      fdrv_q <= fdrv_d;
      tdrv_q <= tdrv_d;
      flash_current_code_q <= flash_ma(flash_d[`LFRB_CODE_MSB:0]);
      torch_current_code_q <= torch_ma(torch_d[`LFRB_CODE_MSB:0]);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output but safety_timeout_o comes straight from a register; that one is decoded from tstate_q.
  assign frame_accepted_o = acc_q;
  assign frame_rejected_o = rej_q;
  assign flash_enable_bit_o = flash_q[`LFRB_EN_BIT];
  assign flash_current_code_o = flash_q[`LFRB_CODE_MSB:0];
  assign torch_enable_bit_o = torch_q[`LFRB_EN_BIT];
  assign torch_current_code_o = torch_q[`LFRB_CODE_MSB:0];
  assign safety_timer_duration_o = dur_q;
  assign low_battery_threshold_o = lbat_q;
  assign safety_current_threshold_o = sth_q;
  assign flash_current_o = flash_current_code_q;
  assign torch_current_o = torch_current_code_q;
  assign flash_drive_o = fdrv_q;
  assign torch_drive_o = tdrv_q;
  assign low_battery_flag_o = lowbat_q;
  assign safety_timeout_o = (tstate_q == LFRB_T_EXPIRED);
  assign shutdown_o = shutdown;

endmodule

// file: lfrb_bank_checker.sv
// Concurrent checks on the ports of the flash LED register bank.
// Assumes a bind to lfrb_bank, one clock and an async active-low reset.
`timescale 1ns/1ps
module lfrb_bank_checker import lfrb_pkg::*; (
  // Clock, reset and frame in.
  input logic clk_i, nrst_i, frame_valid_i,
  input lfrb_count_t frame_addr_i, frame_data_i,
  // Frame result and shutdown.
  input logic frame_accepted_o, frame_rejected_o, shutdown_o,
  // Stored words.
  input logic flash_enable_bit_o, torch_enable_bit_o,
  input logic [3:0] flash_current_code_o, torch_current_code_o, low_battery_threshold_o,
  input logic [2:0] safety_timer_duration_o, safety_current_threshold_o,
  // Currents and driver status.
  input lfrb_tenth_ma_t flash_current_o, torch_current_o,
  input logic flash_drive_o, torch_drive_o, low_battery_flag_o, safety_timeout_o
);
  // ********
  // Helpers
  // ********
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic good;
  logic [19:0] regs;
  // Largest data count per address; zero stands for no register.
  function automatic lfrb_count_t mx(lfrb_count_t a);
    case (a)
      6'h01, 6'h02: mx = 6'h1f;
      6'h03: mx = 6'h07;
      6'h04: mx = 6'h09;
      6'h05: mx = 6'h05;
      default: mx = 6'h00;
    endcase
  endfunction
  // Current in tenths of a milliamp for a four-bit code.
  function automatic lfrb_tenth_ma_t cur(logic [3:0] c, logic fl);
    if (c == 4'hf) cur = fl ? 14'h09c4 : 14'h0271;
    else if (c == 4'he) cur = fl ? 14'h0fa0 : 14'h03e8;
    else cur = fl ? 14'h2ee0 - 14'h01f4 * c : 14'h0bb8 - 14'h007d * c;
  endfunction
  // A frame the bank must take, shutdown aside.
  assign good = frame_valid_i && frame_addr_i >= 6'h01 && frame_addr_i <= 6'h05 && frame_data_i <= mx(frame_addr_i);
  assign regs = {flash_enable_bit_o, flash_current_code_o, torch_enable_bit_o, torch_current_code_o,
                 safety_timer_duration_o, low_battery_threshold_o, safety_current_threshold_o};
  // ********
  // Assertions
  // ********
  a_frame_accept: assert property (good && !shutdown_o |=> frame_accepted_o || shutdown_o)
    else $error("good frame not accepted");
  a_frame_reject: assert property (frame_valid_i && !good |=> frame_rejected_o && !frame_accepted_o)
    else $error("bad frame not rejected");
  a_flash_store: assert property (good && frame_addr_i == 6'h01 && !shutdown_o |=>
    shutdown_o || {flash_enable_bit_o, flash_current_code_o} == $past(frame_data_i[4:0]))
    else $error("flash word not stored");
  a_torch_store: assert property (good && frame_addr_i == 6'h02 && !shutdown_o |=>
    shutdown_o || {torch_enable_bit_o, torch_current_code_o} == $past(frame_data_i[4:0]))
    else $error("torch word not stored");
  a_flash_amps: assert property (flash_current_o == cur(flash_current_code_o, 1'b1))
    else $error("flash current decode");
  a_torch_amps: assert property (torch_current_o == cur(torch_current_code_o, 1'b0))
    else $error("torch current decode");
  a_regs_steady: assert property ($changed(regs) |-> frame_accepted_o || $past(shutdown_o))
    else $error("register moved without frame");
  a_lowbat_off: assert property ($past(low_battery_threshold_o) == 4'h0 |-> !low_battery_flag_o)
    else $error("low battery flag while disabled");
  a_lowbat_stop: assert property (low_battery_flag_o |-> !flash_drive_o && !torch_drive_o)
    else $error("drive on with low battery");
  a_timeout_stop: assert property (safety_timeout_o |-> !flash_drive_o && !torch_drive_o)
    else $error("drive on after timeout");
  a_shut_default: assert property ($rose(shutdown_o) |=> regs == {5'h04, 5'h04, 3'h7, 4'h1, 3'h4})
    else $error("defaults not restored");
  a_shut_reject: assert property (frame_valid_i && shutdown_o |=> frame_rejected_o)
    else $error("frame taken in shutdown");
  c_reject: cover property (frame_rejected_o);
  c_timeout: cover property ($rose(safety_timeout_o));
  c_shutdown: cover property ($rose(shutdown_o));
endmodule

bind lfrb_bank lfrb_bank_checker chk_u (.*);

// file: lfrb_host_model.sv
// Host side of the bank: hands over decoded frames and drives the control line.
// Assumes tasks are called from one bench process, just after a clock edge.
`timescale 1ns/1ps
module lfrb_host_model import lfrb_pkg::*; (
  // Clock.
  input wire logic clk_i,
  // Frame and line toward the bank.
  output logic frame_valid_o,
  output lfrb_count_t frame_addr_o,
  output lfrb_count_t frame_data_o,
  output logic line_o
);
  // Idle line high; stale counts are scrambled so they never pass for fresh ones.
  initial begin
    frame_valid_o = 1'b0;
    frame_addr_o = 6'h2a;
    frame_data_o = 6'h15;
    line_o = 1'b1;
  end
  // One frame, held until the edge that takes it.
  task automatic send(input lfrb_count_t a, input lfrb_count_t d);
    @(posedge clk_i);
    #1;
    frame_valid_o = 1'b1;
    frame_addr_o = a;
    frame_data_o = d;
    @(posedge clk_i);
    #1;
    frame_valid_o = 1'b0;
    frame_addr_o = ~a;
    frame_data_o = ~d;
  endtask
  // Line held low for n cycles, as a host that has gone quiet.
  task automatic hold_low(input int n);
    @(posedge clk_i);
    #1;
    line_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
    line_o = 1'b1;
  endtask
endmodule

// file: tb.sv
// Self-checking bench for the flash LED register bank.
// Assumes the checker and host model are compiled first; counts are shortened.
`timescale 1ns/1ps
module tb import lfrb_pkg::*; ;
  // ********
  // Signals and instances
  // ********
  logic clk = 1'b0, nrst = 1'b0, trig = 1'b0, below = 1'b0;
  logic fv, line, acc, rej, flash_enable_bit, torch_enable_bit, fdrv, tdrv, lbf, tmo, shd;
  lfrb_count_t fa, fd;
  logic [3:0] fc, tc, lbt;
  logic [2:0] dur, sth;
  lfrb_tenth_ma_t fi, ti;
  int n_fail = 0, checks = 0, cyc = 0;
  logic [5:0] maxv [1:5] = '{6'h1f, 6'h1f, 6'h07, 6'h09, 6'h05};
  always #4 clk = ~clk;
  lfrb_host_model host_u (.clk_i(clk), .frame_valid_o(fv), .frame_addr_o(fa), .frame_data_o(fd), .line_o(line));
  lfrb_bank #(.SHUTDOWN_CYCLES(40), .TIMER_STEP_CYCLES(10)) dut_u (
    .clk_i(clk), .nrst_i(nrst), .single_wire_control_line_i(line), .flash_trigger_i(trig),
    .supply_below_threshold_i(below), .frame_valid_i(fv), .frame_addr_i(fa), .frame_data_i(fd),
    .frame_accepted_o(acc), .frame_rejected_o(rej), .flash_enable_bit_o(flash_enable_bit), .flash_current_code_o(fc),
    .torch_enable_bit_o(torch_enable_bit), .torch_current_code_o(tc), .safety_timer_duration_o(dur),
    .low_battery_threshold_o(lbt), .safety_current_threshold_o(sth), .flash_current_o(fi),
    .torch_current_o(ti), .flash_drive_o(fdrv), .torch_drive_o(tdrv), .low_battery_flag_o(lbf),
    .safety_timeout_o(tmo), .shutdown_o(shd));
  // ********
  // Tasks
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input string n, input logic [13:0] e, input logic [13:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // A write returns just after the edge that shows its one-cycle answer.
  task automatic wr(input int a, input int d, input logic ok);
    host_u.send(6'(a), 6'(d));
    cmp("accepted", 14'(ok), 14'(acc));
    cmp("rejected", 14'(!ok), 14'(rej));
  endtask
  task automatic regs(input logic [4:0] f, t, input logic [2:0] d, input logic [3:0] l, input logic [2:0] s);
    cmp("flash word", 14'(f), 14'({flash_enable_bit, fc}));
    cmp("torch word", 14'(t), 14'({torch_enable_bit, tc}));
    cmp("duration", 14'(d), 14'(dur));
    cmp("low battery", 14'(l), 14'(lbt));
    cmp("threshold", 14'(s), 14'(sth));
  endtask
  function automatic lfrb_tenth_ma_t amps(input int c, input logic fl);
    if (c == 15) return fl ? 14'h09c4 : 14'h0271;
    if (c == 14) return fl ? 14'h0fa0 : 14'h03e8;
    return fl ? 14'h2ee0 - 14'(500 * c) : 14'h0bb8 - 14'(125 * c);
  endfunction
  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Cuts a hang short; the whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      summarize();
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    tick(8);
    nrst = 1'b1;
    tick(3);
    regs(5'h04, 5'h04, 3'h7, 4'h1, 3'h4);
    cmp("flash amps", 14'h2710, fi);
    for (int a = 0; a < 7; a++) wr(a, 0, a inside {[1:5]});
    wr(63, 0, 1'b0);
    regs(5'h00, 5'h00, 3'h0, 4'h0, 3'h0);
    for (int a = 1; a < 6; a++) begin
      wr(a, maxv[a], 1'b1);
      wr(a, maxv[a] + 1, 1'b0);
    end
    regs(5'h1f, 5'h1f, 3'h7, 4'h9, 3'h5);
    for (int c = 0; c < 16; c++) begin
      wr(1, c, 1'b1);
      wr(2, c + 16, 1'b1);
      cmp("flash enable", 14'h0000, 14'(flash_enable_bit));
      cmp("flash amps", amps(c, 1'b1), fi);
      cmp("torch enable", 14'h0001, 14'(torch_enable_bit));
      cmp("torch amps", amps(c, 1'b0), ti);
    end
    wr(2, 16, 1'b1);
    wr(1, 5, 1'b1);
    trig = 1'b1;
    tick(4);
    cmp("flash drive", 14'h0001, 14'(fdrv));
    cmp("torch drive", 14'h0000, 14'(tdrv));
    trig = 1'b0;
    tick(4);
    cmp("flash drive", 14'h0000, 14'(fdrv));
    cmp("torch drive", 14'h0001, 14'(tdrv));
    below = 1'b1;
    tick(4);
    cmp("low battery flag", 14'h0001, 14'(lbf));
    cmp("torch drive", 14'h0000, 14'(tdrv));
    wr(4, 0, 1'b1);
    tick(3);
    cmp("low battery flag", 14'h0000, 14'(lbf));
    cmp("torch drive", 14'h0001, 14'(tdrv));
    below = 1'b0;
    wr(3, 0, 1'b1);
    wr(5, 1, 1'b1);
    // One step of running time: still running at the tenth count, expired one edge later.
    tick(10);
    cmp("timeout", 14'h0000, 14'(tmo));
    tick(1);
    cmp("timeout", 14'h0001, 14'(tmo));
    cmp("torch drive", 14'h0000, 14'(tdrv));
    wr(2, 0, 1'b1);
    tick(3);
    cmp("timeout", 14'h0000, 14'(tmo));
    wr(5, 5, 1'b1);
    wr(2, 16, 1'b1);
    tick(20);
    cmp("timeout", 14'h0000, 14'(tmo));
    wr(5, 0, 1'b1);
    wr(1, 16, 1'b1);
    tick(20);
    cmp("timeout", 14'h0000, 14'(tmo));
    cmp("flash drive", 14'h0001, 14'(fdrv));
    fork
      host_u.hold_low(60);
    join_none
    tick(55);
    cmp("shutdown", 14'h0001, 14'(shd));
    regs(5'h04, 5'h04, 3'h7, 4'h1, 3'h4);
    wr(3, 2, 1'b0);
    tick(10);
    cmp("shutdown", 14'h0000, 14'(shd));
    summarize();
  end
endmodule
